// [hdl/fscd_pkg.sv]
// constants for the flash setting command decoder
package fscd_pkg;
   // opcodes
   localparam logic [7:0] SET_WRITE_LATCH_CMD       = 8'h06;
   localparam logic [7:0] CLEAR_WRITE_LATCH_CMD     = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD           = 8'h05;
   localparam logic [7:0] CONFIG_READ_CMD           = 8'h15;
   localparam logic [7:0] STATUS_CONFIG_WRITE_CMD   = 8'h01;
   localparam logic [7:0] UPPER_ADDR_READ_CMD       = 8'hc8;
   localparam logic [7:0] UPPER_ADDR_WRITE_CMD      = 8'hc5;
   localparam logic [7:0] PROTECT_SCHEME_SELECT_CMD = 8'h68;
   localparam logic [7:0] QUAD_MODE_ENTER_CMD       = 8'h35;
   localparam logic [7:0] QUAD_MODE_EXIT_CMD        = 8'hf5;
   localparam logic [7:0] WIDE_ADDR_ENTER_CMD       = 8'hb7;
   localparam logic [7:0] WIDE_ADDR_EXIT_CMD        = 8'he9;
   localparam logic [7:0] WRITE_PAUSE_CMD           = 8'hb0;
   localparam logic [7:0] WRITE_CONTINUE_CMD        = 8'h30;
   localparam logic [7:0] SLEEP_ENTER_CMD           = 8'hb9;
   localparam logic [7:0] SLEEP_EXIT_CMD            = 8'hab;
   localparam logic [7:0] BURST_SIZE_CMD            = 8'hc0;
   localparam logic [7:0] BOOT_REG_READ_CMD         = 8'h16;
   localparam logic [7:0] BOOT_REG_WRITE_CMD        = 8'h17;
   localparam logic [7:0] BOOT_REG_ERASE_CMD        = 8'h18;
   // field positions
   localparam int WRITE_PERMIT_LATCH_BIT = 1;
   localparam int DUMMY_SEL_LOW_BIT      = 6;
   localparam int DUMMY_SEL_HIGH_BIT     = 7;
   // reset and erase values
   localparam logic [7:0]  STATUS_RST   = 8'h00;
   localparam logic [7:0]  CONFIG_RST   = 8'h00;
   localparam logic [7:0]  UPPER_RST    = 8'h00;
   localparam logic [7:0]  BURST_RST    = 8'h00;
   localparam logic [31:0] BOOT_ERASED  = 32'hffffffff;
   // apb register offsets
   localparam logic [7:0] OFS_STATUS  = 8'h00;
   localparam logic [7:0] OFS_CONFIG  = 8'h04;
   localparam logic [7:0] OFS_UPPER   = 8'h08;
   localparam logic [7:0] OFS_MODES   = 8'h0c;
   localparam logic [7:0] OFS_BOOT    = 8'h10;
   localparam logic [7:0] OFS_BURST   = 8'h14;
   localparam logic [7:0] OFS_CTRL    = 8'h18;
   // dummy cycles per dummy select code
   localparam logic [3:0] DUMMY_CODE0 = 4'h8;
   localparam logic [3:0] DUMMY_CODE1 = 4'h6;
   localparam logic [3:0] DUMMY_CODE2 = 4'h8;
   localparam logic [3:0] DUMMY_CODE3 = 4'ha;
endpackage

// [hdl/fscd_top.sv]
// serial flash register and setting command decoder with apb view
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
module fscd_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        link_csn,
   input  wire logic        link_sck,
   input  wire logic [3:0]  link_io_in,
   output logic      [3:0]  link_io_out,
   output logic      [3:0]  link_io_oe,
   output logic             pause_req,
   output logic             continue_req,
   output logic      [3:0]  dummy_cycles
);
   // synchronisers for pins
   logic [5:0] sync1_reg;              // first stage, read only by stage two
   logic [5:0] sync2_reg;              // second stage
   logic       sck_last_reg;           // previous synced clock
   logic       csn_s;                  // synced chip select
   logic       sck_s;                  // synced link clock
   logic [3:0] io_s;                   // synced data lanes
   logic       rise;                   // sampling edge
   logic       fall;                   // shifting edge
   // command state
   logic [7:0]  shift_reg;             // incoming byte
   logic [2:0]  cnt_reg;               // bits or nibbles received
   logic [2:0]  byte_idx_reg;          // bytes received this frame
   logic [7:0]  opcode_reg;            // latched command
   logic [31:0] out_reg;               // outgoing shift data
   logic [2:0]  out_cnt_reg;           // answer length in bytes, never counted down
   logic        byte_done;             // a whole byte arrived
   logic [7:0]  byte_val;              // the arrived byte
   // architectural state
   logic [7:0]  status_reg;            // status register
   logic [7:0]  config_reg;            // configuration register
   logic [7:0]  upper_reg;             // extended address register
   logic [7:0]  burst_reg;             // burst length setting
   logic [31:0] boot_reg;              // fast boot register
   logic        quad_command_mode_reg; // four lane command mode
   logic        wide_addr_flag_reg;    // 4-byte address mode
   logic        protect_mode_reg;      // individual block protect
   logic        sleep_reg;             // deep power down
   logic        suspended_reg;         // program/erase suspended
   logic        busy_reg;              // program/erase in progress (software)
   logic        boot_en_reg;           // fast boot enable shadow
   logic [31:0] boot_shadow_reg;       // boot bytes being collected

   assign csn_s = sync2_reg[5];
   assign sck_s = sync2_reg[4];
   assign io_s  = sync2_reg[3:0];
   assign rise  = !csn_s && sck_s && !sck_last_reg;
   assign fall  = !csn_s && !sck_s && sck_last_reg;

   // two flop synchronisers and edge memory
   // reset image matches the idle pins: deselected, link clock low, lanes high,
   // so the edge finder sees no false edge on the first cycles after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg    <= 6'h2f;
         sync2_reg    <= 6'h2f;
         sck_last_reg <= 1'b0;
      end else if (clk_en) begin
         sync1_reg    <= {link_csn, link_sck, link_io_in};
         sync2_reg    <= sync1_reg;
         sck_last_reg <= sck_s;
      end
   end

   // byte assembly, one bit or one nibble per rising edge
   always_comb begin
      byte_val  = 8'h00;
      byte_done = 1'b0;
      if (rise) begin
         if (quad_command_mode_reg) begin
            byte_val  = {shift_reg[3:0], io_s};
            byte_done = (cnt_reg == 3'd1);
         end else begin
            byte_val  = {shift_reg[6:0], io_s[0]};
            byte_done = (cnt_reg == 3'd7);
         end
      end
   end

   // receive counters, reset by chip select high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_reg    <= 8'h00;
         cnt_reg      <= 3'd0;
         byte_idx_reg <= 3'd0;
         opcode_reg   <= 8'h00;
      end else if (clk_en) begin
         if (csn_s) begin
            cnt_reg      <= 3'd0;
            byte_idx_reg <= 3'd0;
         end else if (rise) begin
            shift_reg <= byte_val;
            cnt_reg   <= byte_done ? 3'd0 : cnt_reg + 3'd1;
            if (byte_done) begin
               if (byte_idx_reg == 3'd0) begin
                  opcode_reg <= byte_val;
               end
               if (byte_idx_reg != 3'd7) begin
                  byte_idx_reg <= byte_idx_reg + 3'd1;
               end
            end
         end
      end
   end

   // command decode on the opcode byte, data handling on later bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg            <= fscd_pkg::STATUS_RST;
         config_reg            <= fscd_pkg::CONFIG_RST;
         upper_reg             <= fscd_pkg::UPPER_RST;
         burst_reg             <= fscd_pkg::BURST_RST;
         boot_reg              <= fscd_pkg::BOOT_ERASED;
         boot_shadow_reg       <= 32'h00000000;
         quad_command_mode_reg <= 1'b0;
         wide_addr_flag_reg    <= 1'b0;
         protect_mode_reg      <= 1'b0;
         sleep_reg             <= 1'b0;
         suspended_reg         <= 1'b0;
         pause_req             <= 1'b0;
         continue_req          <= 1'b0;
      end else if (clk_en) begin
         pause_req    <= 1'b0;
         continue_req <= 1'b0;
         if (byte_done && byte_idx_reg == 3'd0) begin
            if (sleep_reg) begin
               // only wake up is heard while asleep
               if (byte_val == fscd_pkg::SLEEP_EXIT_CMD) begin
                  sleep_reg <= 1'b0;
               end
            end else begin
               case (byte_val)
                  fscd_pkg::SET_WRITE_LATCH_CMD: begin
                     status_reg[fscd_pkg::WRITE_PERMIT_LATCH_BIT] <= 1'b1;
                  end
                  fscd_pkg::CLEAR_WRITE_LATCH_CMD: begin
                     status_reg[fscd_pkg::WRITE_PERMIT_LATCH_BIT] <= 1'b0;
                  end
                  fscd_pkg::PROTECT_SCHEME_SELECT_CMD: begin
                     protect_mode_reg <= 1'b1;
                  end
                  fscd_pkg::QUAD_MODE_ENTER_CMD: begin
                     if (!quad_command_mode_reg) begin
                        quad_command_mode_reg <= 1'b1;
                     end
                  end
                  fscd_pkg::QUAD_MODE_EXIT_CMD: begin
                     if (quad_command_mode_reg) begin
                        quad_command_mode_reg <= 1'b0;
                     end
                  end
                  fscd_pkg::WIDE_ADDR_ENTER_CMD: begin
                     wide_addr_flag_reg <= 1'b1;
                  end
                  fscd_pkg::WIDE_ADDR_EXIT_CMD: begin
                     wide_addr_flag_reg <= 1'b0;
                  end
                  fscd_pkg::WRITE_PAUSE_CMD: begin
                     if (busy_reg) begin
                        suspended_reg <= 1'b1;
                        pause_req     <= 1'b1;
                     end
                  end
                  fscd_pkg::WRITE_CONTINUE_CMD: begin
                     if (suspended_reg) begin
                        suspended_reg <= 1'b0;
                        continue_req  <= 1'b1;
                     end
                  end
                  fscd_pkg::SLEEP_ENTER_CMD: begin
                     sleep_reg <= 1'b1;
                  end
                  fscd_pkg::BOOT_REG_ERASE_CMD: begin
                     if (!quad_command_mode_reg) begin
                        boot_reg <= fscd_pkg::BOOT_ERASED;
                     end
                  end
                  default: begin
                     // unrecognised or multi byte opcode: nothing now
                  end
               endcase
            end
         end else if (byte_done && !sleep_reg) begin
            case (opcode_reg)
               fscd_pkg::STATUS_CONFIG_WRITE_CMD: begin
                  if (byte_idx_reg == 3'd1) begin
                     status_reg <= byte_val;
                  end else if (byte_idx_reg == 3'd2) begin
                     config_reg <= byte_val;
                  end
               end
               fscd_pkg::UPPER_ADDR_WRITE_CMD: begin
                  if (byte_idx_reg == 3'd1) begin
                     upper_reg <= byte_val;
                  end
               end
               fscd_pkg::BURST_SIZE_CMD: begin
                  if (byte_idx_reg == 3'd1) begin
                     burst_reg <= byte_val;
                  end
               end
               fscd_pkg::BOOT_REG_WRITE_CMD: begin
                  if (!quad_command_mode_reg && byte_idx_reg <= 3'd4) begin
                     // least significant byte first
                     boot_shadow_reg <= {byte_val, boot_shadow_reg[31:8]};
                     if (byte_idx_reg == 3'd4) begin
                        boot_reg <= {byte_val, boot_shadow_reg[31:8]};
                     end
                  end
               end
               default: begin
                  // no payload expected
               end
            endcase
         end
      end
   end

   // answer shifting, loaded right after the opcode, advanced on falling edges
   // the word rotates, so a host that clocks past the last byte sees it again
   // from the start; oe falls only once chip select is seen high again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_reg     <= 32'h00000000;
         out_cnt_reg <= 3'd0;
         link_io_out <= 4'h0;
         link_io_oe  <= 4'h0;
      end else if (clk_en) begin
         if (csn_s) begin
            out_cnt_reg <= 3'd0;
            link_io_oe  <= 4'h0;
         end else if (byte_done && byte_idx_reg == 3'd0 && !sleep_reg) begin
            out_cnt_reg <= 3'd1;
            case (byte_val)
               fscd_pkg::STATUS_READ_CMD: begin
                  out_reg <= {status_reg, 24'h000000};
               end
               fscd_pkg::CONFIG_READ_CMD: begin
                  out_reg <= {config_reg, 24'h000000};
               end
               fscd_pkg::UPPER_ADDR_READ_CMD: begin
                  out_reg <= {upper_reg, 24'h000000};
               end
               fscd_pkg::BOOT_REG_READ_CMD: begin
                  // byte order on the wire: lowest byte first
                  out_reg <= {boot_reg[7:0], boot_reg[15:8],
                              boot_reg[23:16], boot_reg[31:24]};
               end
               default: begin
                  out_cnt_reg <= 3'd0;
               end
            endcase
            if (byte_val == fscd_pkg::BOOT_REG_READ_CMD) begin
               out_cnt_reg <= quad_command_mode_reg ? 3'd0 : 3'd4;
            end
         end else if (fall && out_cnt_reg != 3'd0) begin
            if (quad_command_mode_reg) begin
               link_io_out <= out_reg[31:28];
               link_io_oe  <= 4'hf;
               out_reg     <= {out_reg[27:0], out_reg[31:28]};
            end else begin
               link_io_out <= {2'b00, out_reg[31], 1'b0};
               link_io_oe  <= 4'h2;
               out_reg     <= {out_reg[30:0], out_reg[31]};
            end
         end
      end
   end

   // software owned program/erase busy bit and boot enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg    <= 1'b0;
         boot_en_reg <= 1'b0;
      end else if (clk_en) begin
         if (psel && penable && pwrite && paddr == fscd_pkg::OFS_CTRL) begin
            busy_reg    <= pwdata[0];
            boot_en_reg <= pwdata[1];
         end
      end
   end

   // dummy cycle count from configuration bits 7:6
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dummy_cycles <= fscd_pkg::DUMMY_CODE0;
      end else if (clk_en) begin
         case ({config_reg[fscd_pkg::DUMMY_SEL_HIGH_BIT],
                config_reg[fscd_pkg::DUMMY_SEL_LOW_BIT]})
            2'b00:   dummy_cycles <= fscd_pkg::DUMMY_CODE0;
            2'b01:   dummy_cycles <= fscd_pkg::DUMMY_CODE1;
            2'b10:   dummy_cycles <= fscd_pkg::DUMMY_CODE2;
            default: dummy_cycles <= fscd_pkg::DUMMY_CODE3;
         endcase
      end
   end

   // apb slave: single wait free access, read mux registered in setup
   // every register here is read only except ctrl; a write elsewhere is dropped
   // and any offset off the word map answers with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            case (paddr)
               fscd_pkg::OFS_STATUS: prdata <= {24'h000000, status_reg};
               fscd_pkg::OFS_CONFIG: prdata <= {24'h000000, config_reg};
               fscd_pkg::OFS_UPPER:  prdata <= {24'h000000, upper_reg};
               fscd_pkg::OFS_MODES:  prdata <= {26'h0, suspended_reg, sleep_reg,
                                                protect_mode_reg, wide_addr_flag_reg,
                                                quad_command_mode_reg, busy_reg};
               fscd_pkg::OFS_BOOT:   prdata <= boot_reg;
               fscd_pkg::OFS_BURST:  prdata <= {24'h000000, burst_reg};
               fscd_pkg::OFS_CTRL:   prdata <= {30'h0, boot_en_reg, busy_reg};
               default: begin
                  prdata  <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule

// [tb/fscd_top_chk.sv]
// concurrent checks on the ports of the command decoder
`timescale 1ns/100ps
module fscd_top_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        link_csn,
   input wire logic        link_sck,
   input wire logic [3:0]  link_io_in,
   input wire logic [3:0]  link_io_out,
   input wire logic [3:0]  link_io_oe,
   input wire logic        pause_req,
   input wire logic        continue_req,
   input wire logic [3:0]  dummy_cycles
);
   // every check runs on the bus clock and rests during reset
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_APB_ANSWER: assert property (psel && !penable && clk_en |=> pready)
      else $error("apb access cycle without ready");
   AST_READY_ACCESS: assert property (pready |-> psel && penable)
      else $error("ready outside an access cycle");
   AST_READY_ONE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_ERR_MAP: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h18))
      else $error("error response does not match address map");
   AST_DUMMY_CODE: assert property (dummy_cycles inside {4'h6, 4'h8, 4'ha})
      else $error("dummy cycle count outside its table");
   AST_OE_IDLE: assert property (link_csn [*6] |-> link_io_oe == 4'h0)
      else $error("lanes driven while deselected");
   AST_OE_SHAPE: assert property (link_io_oe inside {4'h0, 4'h2, 4'hf})
      else $error("lane enables neither single lane nor quad");
   AST_OUT_HOLD: assert property (link_sck && $past(link_sck) && !link_csn |-> $stable(link_io_out))
      else $error("answer changed while link clock high");
   AST_PAUSE_PULSE: assert property (pause_req |=> !pause_req)
      else $error("suspend pulse longer than one cycle");
   AST_CONT_PULSE: assert property (continue_req |=> !continue_req && !pause_req)
      else $error("resume pulse longer than one cycle");
endmodule
bind fscd_top fscd_top_chk i_fscd_top_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .link_csn, .link_sck, .link_io_in,
   .link_io_out, .link_io_oe, .pause_req, .continue_req, .dummy_cycles);

// [tb/fscd_host.sv]
// host controller model that frames commands on the flash link
`timescale 1ns/100ps
module fscd_host (
   output logic            link_csn,
   output logic            link_sck,
   output logic      [3:0] link_io_in,
   input  wire logic [3:0] link_io_out,
   input  wire logic [3:0] link_io_oe
);
   logic [3:0] drv; // host lane levels, inverted once released
   // wire level: the device wins on every lane it drives
   assign link_io_in = (link_io_oe & link_io_out) | (~link_io_oe & drv);
   // idle: deselected, link clock standing low
   initial begin
      link_csn = 1'b1;
      link_sck = 1'b0;
      drv = 4'h0;
   end
   // select the device; the opcode must be the next byte
   task automatic start();
      link_csn = 1'b0;
      #62.5;
   endtask
   // deselect and let the lanes float to changing values
   task automatic stop();
      #62.5;
      link_csn = 1'b1;
      drv = ~drv;
      #250;
   endtask
   // one byte, msb first; quad sends upper nibble then lower nibble
   task automatic xfer(input logic [7:0] tx, input logic quad, output logic [7:0] rx);
      for (int i = 7; i >= 0; i = i - (quad ? 4 : 1)) begin
         // data changes while the clock is low
         if (quad)
            drv = tx[i -: 4];
         else
            drv = {~drv[3:1], tx[i]};
         #62.5 link_sck = 1'b1;
         // answer taken at the rising edge from the wire, so an undriven lane shows
         // the host's own level instead of the device's output register
         if (quad)
            rx[i -: 4] = link_io_in;
         else
            rx[i] = link_io_in[1];
         #62.5 link_sck = 1'b0;
      end
   endtask
endmodule

// [tb/fscd_top_tb.sv]
// self-checking bench: apb view plus link commands from the host model
`timescale 1ns/100ps
module fscd_top_tb;
   logic        pclk, presetn, clk_en, psel, penable, pwrite; // apb side
   logic [7:0]  paddr;                                        // byte address
   logic [31:0] pwdata, prdata, rx;                           // data words
   logic        pready, pslverr, link_csn, link_sck;          // handshakes and link
   logic        pause_req, continue_req, quad;                // pulses, lane mode
   logic [3:0]  link_io_in, link_io_out, link_io_oe, dummy_cycles;
   int          n_fail, n_tests, n_pause, n_cont;             // counters
   fscd_top i_fscd_top (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .link_csn, .link_sck, .link_io_in, .link_io_out,
      .link_io_oe, .pause_req, .continue_req, .dummy_cycles);
   fscd_host i_fscd_host (.link_csn, .link_sck, .link_io_in, .link_io_out, .link_io_oe);
   // bus clock, 8 ns
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // count suspend and resume pulses
   always @(posedge pclk) begin
      if (pause_req === 1'b1) n_pause++;
      if (continue_req === 1'b1) n_cont++;
   end
   // verdict and end of run
   task automatic wrap_up();
      if (n_fail == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask
   // one apb transfer, held until ready; error expected beyond the map
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      input logic [31:0] e, input logic [31:0] m);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // wait for ready; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      chk({31'h0, pslverr}, {31'h0, a > 8'h18});
      if (!w) chk(prdata & m, e & m);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // read with optional field mask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      apb(1'b0, a, 32'h0, e, m);
   endtask
   // one link frame: opcode then n bytes, first byte in d[7:0]
   task automatic fr(input logic [7:0] op, input int n = 0, input logic [31:0] d = 32'h0);
      logic [7:0] b;
      i_fscd_host.start();
      i_fscd_host.xfer(op, quad, b);
      for (int k = 0; k < n; k++) begin
         i_fscd_host.xfer(d[8*k +: 8], quad, b);
         rx[8*k +: 8] = b;
      end
      i_fscd_host.stop();
   endtask
   // a hang counts as a failure
   initial begin
      #400000;
      n_fail++;
      wrap_up();
   end
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, quad, rx} = '0;
      {n_fail, n_tests, n_pause, n_cont} = '0;
      clk_en = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(fscd_pkg::OFS_STATUS, 32'h0);
      rd(fscd_pkg::OFS_MODES, 32'h0);
      rd(fscd_pkg::OFS_BOOT, fscd_pkg::BOOT_ERASED);
      rd(8'h40, 32'h0);
      chk({28'h0, dummy_cycles}, 32'h8);
      fr(fscd_pkg::SET_WRITE_LATCH_CMD);
      rd(fscd_pkg::OFS_STATUS, 32'h2);
      fr(fscd_pkg::STATUS_READ_CMD, 1);
      chk(rx & 32'hff, 32'h2);
      fr(fscd_pkg::CLEAR_WRITE_LATCH_CMD);
      fr(8'h77);
      rd(fscd_pkg::OFS_STATUS, 32'h0);
      // frozen clock enable: a whole frame passes unseen
      clk_en <= 1'b0;
      fr(fscd_pkg::SET_WRITE_LATCH_CMD);
      @(posedge pclk) clk_en <= 1'b1;
      rd(fscd_pkg::OFS_STATUS, 32'h0);
      // every dummy select code
      for (int c = 0; c < 4; c++) begin
         fr(fscd_pkg::STATUS_CONFIG_WRITE_CMD, 2, {16'h0, c[1:0], 6'h15, 8'h5c});
         rd(fscd_pkg::OFS_CONFIG, {24'h0, c[1:0], 6'h15});
         fr(fscd_pkg::CONFIG_READ_CMD, 1);
         chk(rx & 32'hff, {24'h0, c[1:0], 6'h15});
         chk({28'h0, dummy_cycles}, (c == 1) ? 32'h6 : (c == 3) ? 32'ha : 32'h8);
      end
      fr(fscd_pkg::STATUS_CONFIG_WRITE_CMD, 1, 32'h44);
      rd(fscd_pkg::OFS_CONFIG, 32'hd5);
      apb(1'b1, fscd_pkg::OFS_STATUS, 32'hff, 32'h0, 32'h0);
      rd(fscd_pkg::OFS_STATUS, 32'h44);
      fr(fscd_pkg::UPPER_ADDR_WRITE_CMD, 1, 32'ha5);
      rd(fscd_pkg::OFS_UPPER, 32'ha5);
      fr(fscd_pkg::UPPER_ADDR_READ_CMD, 1);
      chk(rx & 32'hff, 32'ha5);
      fr(fscd_pkg::WIDE_ADDR_ENTER_CMD);
      rd(fscd_pkg::OFS_MODES, 32'h4);
      fr(fscd_pkg::PROTECT_SCHEME_SELECT_CMD);
      fr(fscd_pkg::WIDE_ADDR_EXIT_CMD);
      rd(fscd_pkg::OFS_MODES, 32'h8);
      fr(fscd_pkg::QUAD_MODE_ENTER_CMD);
      quad = 1'b1;
      rd(fscd_pkg::OFS_MODES, 32'ha);
      fr(fscd_pkg::SET_WRITE_LATCH_CMD);
      fr(fscd_pkg::STATUS_READ_CMD, 1);
      chk(rx & 32'hff, 32'h46);
      fr(fscd_pkg::QUAD_MODE_ENTER_CMD);
      fr(fscd_pkg::BOOT_REG_WRITE_CMD, 4, 32'h11223344);
      rd(fscd_pkg::OFS_BOOT, fscd_pkg::BOOT_ERASED);
      fr(fscd_pkg::QUAD_MODE_EXIT_CMD);
      quad = 1'b0;
      rd(fscd_pkg::OFS_MODES, 32'h8);
      fr(fscd_pkg::BOOT_REG_WRITE_CMD, 4, 32'h12345678);
      rd(fscd_pkg::OFS_BOOT, 32'h12345678);
      fr(fscd_pkg::BOOT_REG_READ_CMD, 4);
      chk(rx, 32'h12345678);
      fr(fscd_pkg::BOOT_REG_ERASE_CMD);
      rd(fscd_pkg::OFS_BOOT, fscd_pkg::BOOT_ERASED);
      // suspend refused while idle, then accepted while busy
      fr(fscd_pkg::WRITE_PAUSE_CMD);
      chk(n_pause, 32'h0);
      apb(1'b1, fscd_pkg::OFS_CTRL, 32'h1, 32'h0, 32'h0);
      rd(fscd_pkg::OFS_CTRL, 32'h1, 32'h1);
      fr(fscd_pkg::WRITE_PAUSE_CMD);
      chk(n_pause, 32'h1);
      rd(fscd_pkg::OFS_MODES, 32'h20, 32'h20);
      fr(fscd_pkg::WRITE_CONTINUE_CMD);
      chk(n_cont, 32'h1);
      rd(fscd_pkg::OFS_MODES, 32'h0, 32'h20);
      apb(1'b1, fscd_pkg::OFS_CTRL, 32'h0, 32'h0, 32'h0);
      // while asleep only the wake command is heard
      fr(fscd_pkg::SLEEP_ENTER_CMD);
      rd(fscd_pkg::OFS_MODES, 32'h10, 32'h10);
      fr(fscd_pkg::CLEAR_WRITE_LATCH_CMD);
      rd(fscd_pkg::OFS_STATUS, 32'h46);
      fr(fscd_pkg::SLEEP_EXIT_CMD);
      fr(fscd_pkg::CLEAR_WRITE_LATCH_CMD);
      rd(fscd_pkg::OFS_MODES, 32'h0, 32'h10);
      rd(fscd_pkg::OFS_STATUS, 32'h44);
      fr(fscd_pkg::BURST_SIZE_CMD, 1, 32'h2);
      rd(fscd_pkg::OFS_BURST, 32'h2, 32'hff);
      wrap_up();
   end
endmodule
